// *** rtl/i2bo_top.sv ***
// Build-option register block: SCL counts, target address, data NACK
// control, parameter word and event interrupt for an I2C controller
// Assumes one core clock; slave activity arrives from the link engine
`timescale 1ns/1ps
`include "i2bo_consts.svh"

// What this block does
// R1: Option set to 1, the default, makes interrupt output active high.
// R2: Parameter word bit 7 reads 1 with options, else whole word zero.
// R3: Count registers reset to given counts, else derived from period.
// R4: Hard-coded counts are read-only, else writable; always readable.
// R5: Direct counts imply period 500, 100 or 10 ns by top speed.
// R6: Identical clocks skip synchronisers; other relations synchronise.
// R7: High counts at least 0x0006, low at least 0x0008, 16 bits.
// R8: Standard mode defaults 0x0190 high and 0x01D6 low at 100 MHz.
// R9: Fast mode defaults 0x003C high and 0x0082 low at 100 MHz.
// R10: High-speed defaults 0x006 high and 0x0010 low at 400 pF.
// R11: High-speed builds choose 100 or 400 pF, shaping the derived low count.
// R12: Live update lets target address change during slave transfers.
// R13: NACK control set makes slave NACK, abort and drop each byte.
// R14: NACK control resets to 0; then ordinary acknowledge applies.
// R15: NACK control writes land only if disabled or slave idle.
// R16: FIFO pointer widths are ceil log2 of depth, 1 to 8.
// R17: Counts above the top speed mode are absent.
// R18: Writes to read-only counts complete silently with no change.
module i2bo_top
    import i2bo_pkg::*;
#(
    parameter bit            INTR_POL      = 1'b1,
    parameter bit            ENC_PARAMS    = 1'b1,
    parameter bit            DIRECT_COUNTS = 1'b0,
    parameter bit            HC_COUNTS     = 1'b0,
    parameter int            CORE_PERIOD   = `I2BO_CORE_PERIOD_NS,
    parameter i2bo_speed_t   TOP_SPEED     = SPEED_HIGH,
    parameter i2bo_clk_rel_t CLK_REL       = CLK_ASYNC,
    parameter int            BUS_LOAD_PF   = 400,
    parameter bit            LIVE_TAR      = 1'b0,
    parameter bit            NACK_CTRL_EN  = 1'b1
) (
    input  wire logic          CORE_CLK,
    input  wire logic          SRST,
    input  wire i2bo_bus_req_t BUS_REQ,
    output logic        [31:0] RDATA,
    input  wire logic          SLV_ACT_A,
    input  wire i2bo_rx_byte_t RX_IN,
    output logic               BYTE_ACK,
    output logic               RX_PUSH,
    output logic         [7:0] RX_DATA,
    output logic               XFER_ABORT,
    output logic               CORE_EN,
    output logic         [9:0] TARGET_ADDR,
    output i2bo_scl_cnt_t      SCL_CNT,
    output logic               INTR
);

    // ======================================================================
    // Derived build constants
    localparam int TX_PTR_BITS = $clog2(`I2BO_FIFO_DEPTH);  // [R16]
    localparam int RX_PTR_BITS = $clog2(`I2BO_FIFO_DEPTH);  // [R16]

    // Period the counts stand for
    localparam int EFF_PERIOD = !DIRECT_COUNTS ? CORE_PERIOD :
        (TOP_SPEED == SPEED_STD)  ? `I2BO_STD_PERIOD_NS :
        (TOP_SPEED == SPEED_FAST) ? `I2BO_FAST_PERIOD_NS :
                                    `I2BO_HIGH_PERIOD_NS;   // [R5]

    // Bus load shapes the high-speed low phase
    localparam int HS_LOW_NS = (BUS_LOAD_PF == 100) ?
        `I2BO_HS_LOW_100_NS : `I2BO_HS_LOW_400_NS;          // [R11]

    localparam bit PRES_FAST = (TOP_SPEED != SPEED_STD);   // [R17]
    localparam bit PRES_HS   = (TOP_SPEED == SPEED_HIGH);  // [R17]

    // Least time rounds up, then floor
    function automatic logic [15:0] to_cnt(input int t_ns,
                                           input int p_ns,
                                           input logic [15:0] minv);
        int c;
        c = (t_ns + p_ns - 1) / p_ns;
        if (c > 65535) begin
            c = 65535;
        end
        if (c < int'(minv)) begin
            c = int'(minv);
        end
        return c[15:0];
    endfunction

    localparam logic [15:0] CNT_RST [6] = '{
        DIRECT_COUNTS ? `I2BO_SS_HCNT_DEF :
            to_cnt(`I2BO_SS_HIGH_NS, EFF_PERIOD, `I2BO_HCNT_MIN), // [R8]
        DIRECT_COUNTS ? `I2BO_SS_LCNT_DEF :
            to_cnt(`I2BO_SS_LOW_NS, EFF_PERIOD, `I2BO_LCNT_MIN),  // [R8]
        DIRECT_COUNTS ? `I2BO_FS_HCNT_DEF :
            to_cnt(`I2BO_FS_HIGH_NS, EFF_PERIOD, `I2BO_HCNT_MIN), // [R9]
        DIRECT_COUNTS ? `I2BO_FS_LCNT_DEF :
            to_cnt(`I2BO_FS_LOW_NS, EFF_PERIOD, `I2BO_LCNT_MIN),  // [R9]
        DIRECT_COUNTS ? `I2BO_HS_HCNT_DEF :
            to_cnt(`I2BO_HS_HIGH_NS, EFF_PERIOD, `I2BO_HCNT_MIN), // [R10]
        DIRECT_COUNTS ? `I2BO_HS_LCNT_DEF :
            to_cnt(HS_LOW_NS, EFF_PERIOD, `I2BO_LCNT_MIN)         // [R10]
    };

    localparam logic [15:0] CNT_MIN [6] = '{
        `I2BO_HCNT_MIN, `I2BO_LCNT_MIN, `I2BO_HCNT_MIN,
        `I2BO_LCNT_MIN, `I2BO_HCNT_MIN, `I2BO_LCNT_MIN
    };

    localparam logic [5:0] CNT_PRES = {
        PRES_HS, PRES_HS, PRES_FAST, PRES_FAST, 1'b1, 1'b1
    };

    // Self-description word
    localparam logic [31:0] PARAM_WORD = !ENC_PARAMS ? 32'h00000000 : {
        8'(`I2BO_FIFO_DEPTH - 1), 8'(`I2BO_FIFO_DEPTH - 1),
        4'(RX_PTR_BITS), 4'(TX_PTR_BITS),
        1'b1, DIRECT_COUNTS, NACK_CTRL_EN, LIVE_TAR,
        INTR_POL, HC_COUNTS, TOP_SPEED
    };                                                     // [R2]

    // ======================================================================
    // Slave activity crossing
    logic slv_act;

    generate
        if (CLK_REL == CLK_IDENT) begin : g_direct
            assign slv_act = SLV_ACT_A;                    // [R6]
        end else begin : g_sync
            logic s1_q;
            logic s2_q;
            logic s3_q;
            logic act_q;

            always_ff @(posedge CORE_CLK) begin
                if (SRST) begin
                    s1_q  <= 1'b0;
                    s2_q  <= 1'b0;
                    s3_q  <= 1'b0;
                    act_q <= 1'b0;
                end else begin
                    s1_q  <= SLV_ACT_A;
                    s2_q  <= s1_q;
                    s3_q  <= s2_q;
                    act_q <= (s2_q == s3_q) ? s3_q : act_q;  // [R6]
                end
            end

            assign slv_act = act_q;

            a_sync_agree: assert property (@(posedge CORE_CLK)  // [R6]
                disable iff (SRST)
                $changed(act_q) |-> $past(s2_q) == $past(s3_q))
                else $error("activity moved before agreement");
        end
    endgenerate

    // ======================================================================
    // Register decode
    logic                    enable_q;
    logic              [9:0] tar_q;
    logic                    nack_q;
    logic [`I2BO_EV_BITS-1:0] stat_q;
    logic [`I2BO_EV_BITS-1:0] stat_d;
    logic [`I2BO_EV_BITS-1:0] ien_q;
    logic             [31:0] rdata_q;
    logic             [31:0] rdata_d;
    logic              [5:0][15:0] cnt_val;

    wire logic wr = BUS_REQ.wr;
    wire logic [7:0] adr = BUS_REQ.addr;
    wire logic wr_enable = wr && (adr == `I2BO_OFF_ENABLE);
    wire logic wr_target = wr && (adr == `I2BO_OFF_TARGET);
    wire logic wr_nack   = wr && (adr == `I2BO_OFF_NACK) && NACK_CTRL_EN;
    wire logic wr_ien    = wr && (adr == `I2BO_OFF_INT_EN);
    wire logic wr_iclr   = wr && (adr == `I2BO_OFF_INT_CLR);

    // Target change blocked mid-transfer unless live update
    wire logic tar_ok    = LIVE_TAR || !slv_act;               // [R12]
    wire logic tar_take  = wr_target && tar_ok;
    wire logic tar_deny  = wr_target && !tar_ok;
    // NACK control only moves while disabled or slave idle
    wire logic nack_ok   = !enable_q || !slv_act;              // [R15]
    wire logic nack_take = wr_nack && nack_ok;

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            enable_q <= 1'b0;
            tar_q    <= `I2BO_TAR_RST;
            nack_q   <= 1'b0;                                  // [R14]
            ien_q    <= '0;
        end else begin
            enable_q <= wr_enable ? BUS_REQ.wdata[`I2BO_EN_BIT] : enable_q;
            tar_q    <= tar_take ? BUS_REQ.wdata[9:0] : tar_q;  // [R12]
            nack_q   <= nack_take ? BUS_REQ.wdata[0] : nack_q;  // [R15]
            ien_q    <= wr_ien ? BUS_REQ.wdata[`I2BO_EV_BITS-1:0] : ien_q;
        end
    end

    // ======================================================================
    // SCL count registers
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_cnt
            localparam logic [7:0] OFF = 8'(`I2BO_OFF_CNT_BASE + 4 * gi);

            i2bo_cnt_reg #(
                .RST_VAL   (CNT_RST[gi]),
                .MIN_VAL   (CNT_MIN[gi]),
                .PRESENT   (CNT_PRES[gi]),
                .HARDCODED (HC_COUNTS)
            ) u_cnt (
                .clk   (CORE_CLK),
                .srst  (SRST),
                .wr_en (wr && (adr == OFF)),
                .wdata (BUS_REQ.wdata[15:0]),
                .value (cnt_val[gi])
            );
        end
    endgenerate

    assign SCL_CNT = {cnt_val[0], cnt_val[1], cnt_val[2],
                      cnt_val[3], cnt_val[4], cnt_val[5]};

    // ======================================================================
    // Slave receive byte handling
    logic       ack_q;
    logic       push_q;
    logic       abort_q;
    logic [7:0] rxd_q;

    wire logic drop_byte = RX_IN.valid && nack_q;              // [R13]
    wire logic keep_byte = RX_IN.valid && !nack_q && RX_IN.ord_ack;

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            ack_q   <= 1'b0;
            push_q  <= 1'b0;
            abort_q <= 1'b0;
            rxd_q   <= 8'h00;
        end else begin
            ack_q   <= RX_IN.valid ? (!nack_q && RX_IN.ord_ack)
                                   : ack_q;                    // [R13] [R14]
            push_q  <= keep_byte;                              // [R14]
            abort_q <= drop_byte;                              // [R13]
            rxd_q   <= keep_byte ? RX_IN.data : rxd_q;
        end
    end

    assign BYTE_ACK   = ack_q;
    assign RX_PUSH    = push_q;
    assign RX_DATA    = rxd_q;
    assign XFER_ABORT = abort_q;

    // ======================================================================
    // Events and interrupt
    wire logic [`I2BO_EV_BITS-1:0] events = {tar_deny, drop_byte, keep_byte};
    wire logic [`I2BO_EV_BITS-1:0] clr_mask =
        wr_iclr ? BUS_REQ.wdata[`I2BO_EV_BITS-1:0] : '0;
    wire logic irq = |(stat_q & ien_q);

    // Set wins over clear
    assign stat_d = (stat_q & ~clr_mask) | events;

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            stat_q <= '0;
        end else begin
            stat_q <= stat_d;
        end
    end

    assign INTR = INTR_POL ? irq : !irq;                       // [R1]

    // ======================================================================
    // Read path
    always_comb begin
        rdata_d = 32'h00000000;
        unique case (adr)
            `I2BO_OFF_ENABLE:   rdata_d = {31'h00000000, enable_q};
            `I2BO_OFF_TARGET:   rdata_d = {22'h000000, tar_q};
            `I2BO_OFF_STATUS: begin
                rdata_d[`I2BO_EN_BIT]      = enable_q;
                rdata_d[`I2BO_SLV_ACT_BIT] = slv_act;
            end
            `I2BO_OFF_NACK:     rdata_d = {31'h00000000, nack_q};
            `I2BO_OFF_INT_STAT: rdata_d = 32'(stat_q);
            `I2BO_OFF_INT_EN:   rdata_d = 32'(ien_q);
            `I2BO_OFF_PARAM:    rdata_d = PARAM_WORD;          // [R2]
            default: begin
                for (int k = 0; k < 6; k++) begin
                    if (adr == 8'(`I2BO_OFF_CNT_BASE + 4 * k)) begin
                        rdata_d = {16'h0000, cnt_val[k]};      // [R4]
                    end
                end
            end
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            rdata_q <= 32'h00000000;
        end else begin
            rdata_q <= BUS_REQ.rd ? rdata_d : 32'h00000000;
        end
    end

    assign RDATA       = rdata_q;
    assign CORE_EN     = enable_q;
    assign TARGET_ADDR = tar_q;

    // ======================================================================
    // Checks
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SRST);

    sequence s_drop;
        RX_IN.valid && nack_q;
    endsequence

    sequence s_dropped;
        !BYTE_ACK && XFER_ABORT && !RX_PUSH;
    endsequence

    a_intr_raise: assert property (                            // [R1]
        (|(events & ien_q) && !wr_ien) |=> INTR == INTR_POL)
        else $error("interrupt level wrong after event");

    a_param_read: assert property (                            // [R2]
        (BUS_REQ.rd && adr == `I2BO_OFF_PARAM) |=>
        RDATA == PARAM_WORD && RDATA[`I2BO_PARAM_FLAG] == ENC_PARAMS)
        else $error("parameter word read wrong");

    a_tar_guard: assert property (                             // [R12]
        (wr_target && slv_act && !LIVE_TAR) |=>
        $stable(tar_q) && stat_q[`I2BO_EV_TAR_REFUSE])
        else $error("target changed during transfer");

    a_nack_drop: assert property (s_drop |=> s_dropped)        // [R13]
        else $error("byte not refused under nack control");

    a_nack_reset: assert property (                            // [R14]
        $past(SRST) |-> !nack_q)
        else $error("nack control not cleared by reset");

    a_nack_guard: assert property (                            // [R15]
        (wr_nack && enable_q && slv_act) |=> $stable(nack_q))
        else $error("nack control written while busy");

    a_set_wins: assert property (                              // [R13]
        (drop_byte && wr_iclr && BUS_REQ.wdata[`I2BO_EV_NACK]) |=>
        stat_q[`I2BO_EV_NACK] && (INTR == INTR_POL || !ien_q[`I2BO_EV_NACK]))
        else $error("event lost to clear");

endmodule

// *** rtl/i2bo_consts.svh ***
// Offsets, field positions, reset values and timing figures of the block
// Assumes inclusion by bare name from the package users
`ifndef I2BO_CONSTS_SVH
`define I2BO_CONSTS_SVH

// ==========================================================================
// Register byte offsets
`define I2BO_OFF_ENABLE    8'h00
`define I2BO_OFF_TARGET    8'h04
`define I2BO_OFF_STATUS    8'h08
`define I2BO_OFF_NACK      8'h0C
`define I2BO_OFF_CNT_BASE  8'h10
`define I2BO_OFF_INT_STAT  8'h28
`define I2BO_OFF_INT_EN    8'h2C
`define I2BO_OFF_INT_CLR   8'h30
`define I2BO_OFF_PARAM     8'h34

// ==========================================================================
// Field positions
`define I2BO_EN_BIT        0
`define I2BO_SLV_ACT_BIT   6
`define I2BO_PARAM_FLAG    7
`define I2BO_EV_PUSH       0
`define I2BO_EV_NACK       1
`define I2BO_EV_TAR_REFUSE 2
`define I2BO_EV_BITS       3

// ==========================================================================
// Reset values and count limits
`define I2BO_TAR_RST       10'h055
`define I2BO_SS_HCNT_DEF   16'h0190
`define I2BO_SS_LCNT_DEF   16'h01D6
`define I2BO_FS_HCNT_DEF   16'h003C
`define I2BO_FS_LCNT_DEF   16'h0082
`define I2BO_HS_HCNT_DEF   16'h0006
`define I2BO_HS_LCNT_DEF   16'h0010
`define I2BO_HCNT_MIN      16'h0006
`define I2BO_LCNT_MIN      16'h0008

// ==========================================================================
// Timing figures in ns
`define I2BO_CORE_PERIOD_NS 10
`define I2BO_STD_PERIOD_NS 500
`define I2BO_FAST_PERIOD_NS 100
`define I2BO_HIGH_PERIOD_NS 10
`define I2BO_SS_HIGH_NS    4000
`define I2BO_SS_LOW_NS     4700
`define I2BO_FS_HIGH_NS    600
`define I2BO_FS_LOW_NS     1300
`define I2BO_HS_HIGH_NS    60
`define I2BO_HS_LOW_400_NS 160
`define I2BO_HS_LOW_100_NS 120

// ==========================================================================
// FIFO geometry
`define I2BO_FIFO_DEPTH    8

`endif

// *** rtl/i2bo_pkg.sv ***
// Types shared by the build-option block and its count registers
// Assumes the constants header is compiled alongside
package i2bo_pkg;

    typedef enum logic [1:0] {
        SPEED_STD  = 2'b01,
        SPEED_FAST = 2'b10,
        SPEED_HIGH = 2'b11
    } i2bo_speed_t;

    typedef enum logic [1:0] {
        CLK_IDENT = 2'b00,
        CLK_ASYNC = 2'b01,
        CLK_SYNC  = 2'b11
    } i2bo_clk_rel_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } i2bo_bus_req_t;

    typedef struct packed {
        logic       valid;
        logic       ord_ack;
        logic [7:0] data;
    } i2bo_rx_byte_t;

    typedef struct packed {
        logic [15:0] std_high;
        logic [15:0] std_low;
        logic [15:0] fast_high;
        logic [15:0] fast_low;
        logic [15:0] hs_high;
        logic [15:0] hs_low;
    } i2bo_scl_cnt_t;

endpackage

// *** rtl/i2bo_cnt_reg.sv ***
// One SCL count register with floor, presence and hard-coding options
// Assumes write strobe already decoded by the parent on the same clock
`timescale 1ns/1ps
`include "i2bo_consts.svh"

module i2bo_cnt_reg
    import i2bo_pkg::*;
#(
    parameter logic [15:0] RST_VAL   = 16'h0010,
    parameter logic [15:0] MIN_VAL   = 16'h0008,
    parameter bit          PRESENT   = 1'b1,
    parameter bit          HARDCODED = 1'b0
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        wr_en,
    input  wire logic [15:0] wdata,
    output logic      [15:0] value
);

    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    wire  logic  below_min;
    wire  logic  take_wr;

    // ======================================================================
    // Update
    assign below_min = (wdata < MIN_VAL);
    assign take_wr   = wr_en && PRESENT && !HARDCODED;  // [R4] [R18]
    assign cnt_d     = !take_wr ? cnt_q :
                       below_min ? MIN_VAL : wdata;     // [R7]

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_q <= PRESENT ? RST_VAL : 16'h0000;      // [R3] [R17]
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign value = cnt_q;

    // ======================================================================
    // Checks
    a_cnt_floor: assert property (@(posedge clk) disable iff (srst)  // [R7]
        PRESENT |-> value >= MIN_VAL)
        else $error("count below floor");

    a_cnt_frozen: assert property (@(posedge clk) disable iff (srst) // [R4]
        (wr_en && HARDCODED) |=> $stable(value))
        else $error("hard-coded count changed");

    a_cnt_reset: assert property (@(posedge clk)                     // [R3]
        srst |=> value == (PRESENT ? RST_VAL : 16'h0000))
        else $error("count reset value wrong");

endmodule

// *** dv/i2bo_link_model.sv ***
// Behavioural link engine feeding received bytes and slave activity
// Assumes the bench drives its controls right after rising edges
`timescale 1ns/1ps

module i2bo_link_model
    import i2bo_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       send,
    input  wire logic [7:0] sbyte,
    input  wire logic       sack,
    input  wire logic       act,
    output logic            slv_act_a,
    output i2bo_rx_byte_t   rx_in
);
    // ======================================================================
    // One byte per send; idle lines toggle so stale data never looks valid
    always_ff @(posedge clk) begin
        if (srst) begin
            rx_in <= '0;
            slv_act_a <= 1'b0;
        end else begin
            rx_in.valid <= send;
            rx_in.ord_ack <= send ? sack : ~rx_in.ord_ack;
            rx_in.data <= send ? sbyte : ~rx_in.data;
            slv_act_a <= act;
        end
    end
endmodule

// *** dv/i2bo_top_tb_top.sv ***
// Self-checking bench for the build-option register block
// Assumes default build options and the link model on the far side
`timescale 1ns/1ps
`include "i2bo_consts.svh"

module i2bo_top_tb_top
    import i2bo_pkg::*;
;
    logic          CORE_CLK;
    logic          SRST;
    i2bo_bus_req_t BUS_REQ;
    logic   [31:0] RDATA;
    logic          SLV_ACT_A;
    i2bo_rx_byte_t RX_IN;
    logic          BYTE_ACK;
    logic          RX_PUSH;
    logic    [7:0] RX_DATA;
    logic          XFER_ABORT;
    logic          CORE_EN;
    logic    [9:0] TARGET_ADDR;
    i2bo_scl_cnt_t SCL_CNT;
    logic          INTR;
    logic          send;
    logic    [7:0] sbyte;
    logic          sack;
    logic          act;
    logic   [31:0] rv;
    logic   [31:0] RDATA_B;
    logic          INTR_B;
    logic   [31:0] rv_b;
    logic   [15:0] v;
    int            err_count;
    int            compares;
    int            seed;

    i2bo_top i_dut (.CORE_CLK(CORE_CLK), .SRST(SRST), .BUS_REQ(BUS_REQ),
        .RDATA(RDATA), .SLV_ACT_A(SLV_ACT_A), .RX_IN(RX_IN),
        .BYTE_ACK(BYTE_ACK), .RX_PUSH(RX_PUSH), .RX_DATA(RX_DATA),
        .XFER_ABORT(XFER_ABORT), .CORE_EN(CORE_EN),
        .TARGET_ADDR(TARGET_ADDR), .SCL_CNT(SCL_CNT), .INTR(INTR));
    // Second build: hard-coded standard-only counts, no word, low irq
    i2bo_top #(.INTR_POL(1'b0), .ENC_PARAMS(1'b0), .HC_COUNTS(1'b1),
        .TOP_SPEED(SPEED_STD), .CLK_REL(CLK_IDENT)) i_dut_b (
        .CORE_CLK(CORE_CLK), .SRST(SRST), .BUS_REQ(BUS_REQ),
        .RDATA(RDATA_B), .SLV_ACT_A(SLV_ACT_A), .RX_IN(RX_IN),
        .BYTE_ACK(), .RX_PUSH(), .RX_DATA(), .XFER_ABORT(), .CORE_EN(),
        .TARGET_ADDR(), .SCL_CNT(), .INTR(INTR_B));
    i2bo_link_model i_link (.clk(CORE_CLK), .srst(SRST), .send(send),
        .sbyte(sbyte), .sack(sack), .act(act), .slv_act_a(SLV_ACT_A),
        .rx_in(RX_IN));

    // ======================================================================
    // Bus and link tasks
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CORE_CLK);
        BUS_REQ <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge CORE_CLK);
        BUS_REQ.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge CORE_CLK);
        BUS_REQ <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge CORE_CLK);
        BUS_REQ.rd <= 1'b0;
        #1 rv = RDATA;
        rv_b = RDATA_B;
    endtask
    task automatic rx(input logic [7:0] d, input logic k);
        @(posedge CORE_CLK);
        send <= 1'b1;
        sbyte <= d;
        sack <= k;
        @(posedge CORE_CLK);
        send <= 1'b0;
        @(posedge CORE_CLK);
        #1;
    endtask
    task automatic wait_act(input logic lvl);
        int n;
        n = 0;
        act <= lvl;
        do begin
            rd(`I2BO_OFF_STATUS);
            n++;
        end while (rv[`I2BO_SLV_ACT_BIT] !== lvl && n < 20);
        if (rv[`I2BO_SLV_ACT_BIT] !== lvl) begin
            err_count++;
            end_sim();
        end
    endtask
    task automatic end_sim();
        if (err_count == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    function automatic logic [15:0] floor_cnt(input int i,
                                             input logic [15:0] x);
        logic [15:0] f;
        f = i[0] ? `I2BO_LCNT_MIN : `I2BO_HCNT_MIN;
        return (x < f) ? f : x;
    endfunction

    initial begin
        CORE_CLK = 1'b0;
        forever #5 CORE_CLK = ~CORE_CLK;
    end

    // ======================================================================
    // Main sequence
    initial begin
        logic [15:0] defs [6];
        defs = '{`I2BO_SS_HCNT_DEF, `I2BO_SS_LCNT_DEF, `I2BO_FS_HCNT_DEF,
                 `I2BO_FS_LCNT_DEF, `I2BO_HS_HCNT_DEF, `I2BO_HS_LCNT_DEF};
        seed = 34;
        err_count = 0;
        compares = 0;
        SRST = 1'b1;
        BUS_REQ = '0;
        {send, sbyte, sack, act} = '0;
        repeat (20) @(posedge CORE_CLK);
        SRST <= 1'b0;
        chk("intr_rst", 32'h0, INTR);
        chk("intr_rst_b", 32'h1, INTR_B);
        for (int i = 0; i < 6; i++) begin
            rd(`I2BO_OFF_CNT_BASE + 8'(4 * i));
            chk("cnt_rst", defs[i], rv);
            chk("cnt_rst_b", (i < 2) ? 32'(defs[i]) : 32'h0,
                rv_b);
        end
        rd(`I2BO_OFF_PARAM);
        chk("param", 32'h0707_33AB, rv);
        chk("param_b", 32'h0, rv_b);
        @(posedge CORE_CLK);
        #1 chk("rdata_idle", 32'h0, RDATA);
        rd(`I2BO_OFF_NACK);
        chk("nack_rst", 32'h0, rv);
        rd(`I2BO_OFF_TARGET);
        chk("tgt_rst", 32'h055, rv);
        rd(8'h3C);
        chk("unmapped", 32'h0, rv);
        for (int j = 0; j < 4; j++) begin
            for (int i = 0; i < 6; i++) begin
                v = (j == 0) ? 16'h0002 :
                    (j == 1) ? 16'hFFFF : 16'($random(seed));
                wr(`I2BO_OFF_CNT_BASE + 8'(4 * i), {16'hFFFF, v});
                rd(`I2BO_OFF_CNT_BASE + 8'(4 * i));
                chk("cnt_wr", 32'(floor_cnt(i, v)), rv);
                chk("cnt_hc", (i < 2) ? 32'(defs[i]) : 32'h0,
                    rv_b);
            end
        end
        chk("cnt_port", 32'(floor_cnt(5, v)), SCL_CNT.hs_low);
        for (int i = 0; i < 4; i++) begin
            v = 16'($random(seed));
            rx(v[7:0], i[0]);
            chk("ack", 32'(i[0]), BYTE_ACK);
            chk("push", 32'(i[0]), RX_PUSH);
            chk("abort", 32'h0, XFER_ABORT);
            if (i[0]) chk("rx_data", 32'(v[7:0]), RX_DATA);
        end
        wr(`I2BO_OFF_ENABLE, 32'h1);
        #1 chk("core_en", 32'h1, CORE_EN);
        wait_act(1'b1);
        wr(`I2BO_OFF_NACK, 32'h1);
        rd(`I2BO_OFF_NACK);
        chk("nack_busy", 32'h0, rv);
        wr(`I2BO_OFF_INT_CLR, 32'h7);
        wr(`I2BO_OFF_TARGET, 32'h123);
        rd(`I2BO_OFF_TARGET);
        chk("tgt_busy", 32'h055, rv);
        rd(`I2BO_OFF_INT_STAT);
        chk("int_stat", 32'h4, rv & 32'h4);
        chk("intr_mask", 32'h0, INTR);
        wr(`I2BO_OFF_INT_EN, 32'h4);
        #1 chk("intr_on", 32'h1, INTR);
        chk("intr_on_b", 32'h0, INTR_B);
        wr(`I2BO_OFF_INT_CLR, 32'h4);
        #1 chk("intr_clr", 32'h0, INTR);
        wait_act(1'b0);
        wr(`I2BO_OFF_TARGET, 32'h123);
        #1 chk("tgt_idle", 32'h123, TARGET_ADDR);
        wr(`I2BO_OFF_NACK, 32'h1);
        rd(`I2BO_OFF_NACK);
        chk("nack_idle", 32'h1, rv);
        rx(8'h5A, 1'b1);
        chk("drop_ack", 32'h0, BYTE_ACK);
        chk("drop_push", 32'h0, RX_PUSH);
        chk("drop_abort", 32'h1, XFER_ABORT);
        rd(`I2BO_OFF_INT_STAT);
        chk("drop_evt", 32'h2, rv & 32'h3);
        // Drop lands in the same cycle as a clear of its status bit
        fork
            rx(8'h5A, 1'b1);
            begin
                @(posedge CORE_CLK);
                wr(`I2BO_OFF_INT_CLR, 32'h2);
            end
        join
        rd(`I2BO_OFF_INT_STAT);
        chk("set_wins", 32'h2, rv & 32'h2);
        end_sim();
    end
endmodule
